// ===== test_ucs_uart.sv
`timescale 1ns/100ps
`include "ucs_defs.svh"
module test_ucs_uart;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`UCS_ADDR_W-1:0] bus_addr = '0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic serial_rx;
    logic serial_tx;
    logic cts_n = 1'b1;
    logic irq;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 sys_clk = ~sys_clk;
    ucs_uart dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .serial_rx(serial_rx),
        .serial_tx(serial_tx), .cts_n(cts_n), .irq(irq));
    ucs_remote #(.BIT_CLKS(32)) remote (.sys_clk(sys_clk),
        .line_in(serial_tx), .line_out(serial_rx));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rchk(string n, logic [11:0] a, logic [7:0] m,
                        logic [7:0] e);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 chk(n, e, bus_rdata & m);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk("ctl0", `UCS_OFF_CTL0, 8'hFF, 8'h00);
        rchk("stat1", `UCS_OFF_STAT1, 8'hFF, 8'h00);
        rchk("unmapped", 12'hF45, 8'hFF, 8'h00);
        rchk("stat0", `UCS_OFF_STAT0, 8'h07, 8'h07);
        wr(`UCS_OFF_CTL0, 8'hDB);
        rchk("ctl0", `UCS_OFF_CTL0, 8'hFF, 8'hDB);
        wr(`UCS_OFF_CTL0, 8'h00);
        wr(`UCS_OFF_DIV_LO, 8'h02);
        $display("registers done");
        wr(`UCS_OFF_CTL0, 8'hA0);
        rchk("ctl0", `UCS_OFF_CTL0, 8'hFF, 8'hA0);
        wr(`UCS_OFF_DATA, 8'h5A);
        rchk("hold_empty", `UCS_OFF_STAT0, 8'h04, 8'h00);
        repeat (100) @(posedge sys_clk);
        chk("tx_held", 8'h01, {7'h00, serial_tx});
        cts_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rchk("cts", `UCS_OFF_STAT0, 8'h01, 8'h00);
        repeat (40) @(posedge sys_clk);
        rchk("busy", `UCS_OFF_STAT0, 8'h06, 8'h04);
        repeat (400) @(posedge sys_clk);
        chk("tx_byte", 8'h5A, remote.got);
        chk("bit_time", 8'h20, remote.bit_clks[7:0]);
        rchk("idle", `UCS_OFF_STAT0, 8'h06, 8'h06);
        rchk("ist_tx", `UCS_OFF_IST, 8'h02, 8'h02);
        wr(`UCS_OFF_CTL0, 8'h00);
        $display("transmit done");
        wr(`UCS_OFF_IMASK, 8'h01);
        wr(`UCS_OFF_CTL0, 8'h40);
        remote.send(8'h3C, 1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge sys_clk);
        chk("irq", 8'h01, {7'h00, irq});
        rchk("ist", `UCS_OFF_IST, 8'h01, 8'h01);
        rchk("ferr", `UCS_OFF_STAT0, 8'h10, 8'h00);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'h3C);
        chk("irq_off", 8'h00, {7'h00, irq});
        remote.send(8'hA5, 1'b0, 1'b0, 1'b0);
        rchk("ist_err", `UCS_OFF_IST, 8'h04, 8'h04);
        rchk("ferr", `UCS_OFF_STAT0, 8'h10, 8'h10);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'hA5);
        remote.send(8'h00, 1'b0, 1'b0, 1'b0);
        rchk("brk", `UCS_OFF_STAT0, 8'h08, 8'h08);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'h00);
        rchk("brk", `UCS_OFF_STAT0, 8'h08, 8'h00);
        wr(`UCS_OFF_CTL0, 8'h00);
        wr(`UCS_OFF_CTL0, 8'h58);
        remote.send(8'h3C, 1'b1, 1'b0, 1'b1);
        rchk("perr", `UCS_OFF_STAT0, 8'h40, 8'h40);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'h3C);
        $display("receive done");
        wr(`UCS_OFF_CTL0, 8'h00);
        wr(`UCS_OFF_CTL1, 8'h80);
        wr(`UCS_OFF_CTL0, 8'h40);
        remote.send(8'h11, 1'b1, 1'b1, 1'b1);
        rchk("mp_addr", `UCS_OFF_STAT1, 8'h03, 8'h01);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'h11);
        remote.send(8'h22, 1'b1, 1'b0, 1'b1);
        rchk("first_frame_byte_flag", `UCS_OFF_STAT1, 8'h03, 8'h02);
        rchk("rx_byte", `UCS_OFF_DATA, 8'hFF, 8'h22);
        rchk("first_frame_byte_flag", `UCS_OFF_STAT1, 8'h03, 8'h00);
        $display("multiprocessor done");
        wr(`UCS_OFF_CTL0, 8'h04);
        rchk("ctl0", `UCS_OFF_CTL0, 8'hFF, 8'h04);
        repeat (5) @(posedge sys_clk);
        chk("break_tx", 8'h00, {7'h00, serial_tx});
        wr(`UCS_OFF_CTL0, 8'h00);
        rchk("ist", `UCS_OFF_IST, 8'h08, 8'h00);
        wr(`UCS_OFF_CTL1, 8'h02);
        repeat (10) @(posedge sys_clk);
        rchk("timer", `UCS_OFF_IST, 8'h08, 8'h08);
        $display("timer done");
        end_of_test();
    end
endmodule
bind ucs_uart ucs_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .cts_n(cts_n), .irq(irq));

// ===== ucs_checker.sv
`timescale 1ns/100ps
`include "ucs_defs.svh"
module ucs_checker
    import ucs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`UCS_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic serial_rx,
    input wire logic serial_tx,
    input wire logic cts_n,
    input wire logic irq
);
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [3:0] msk_q;
    logic [3:0] msk_d;
    // Shadows of the control and mask registers as software wrote them
    always_comb begin
        ctl_d = ctl_q;
        msk_d = msk_q;
        if (bus_wr && bus_addr == `UCS_OFF_CTL0) begin
            ctl_d = bus_wdata;
        end
        if (bus_wr && bus_addr == `UCS_OFF_IMASK) begin
            msk_d = bus_wdata[3:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            msk_q <= 4'h0;
        end else begin
            ctl_q <= ctl_d;
            msk_q <= msk_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_ctl;
        bus_rd && bus_addr == `UCS_OFF_CTL0;
    endsequence
    sequence s_rd_stat0;
        bus_rd && bus_addr == `UCS_OFF_STAT0;
    endsequence
    sequence s_rd_stat1;
        bus_rd && bus_addr == `UCS_OFF_STAT1;
    endsequence
    a_ctl_readback: assert property (
        s_rd_ctl |=> bus_rdata == $past(ctl_q)) else $error("ctl0 readback");
    a_stat1_resv: assert property (
        s_rd_stat1 |=> bus_rdata[7:2] == 6'h00) else $error("stat1 reserved");
    a_cts_level: assert property (
        s_rd_stat0 |=> bus_rdata[0] == $past(cts_n)) else $error("cts level");
    a_rdata_idle: assert property (
        !bus_rd |=> bus_rdata == 8'h00) else $error("rdata not idle");
    a_unmapped_zero: assert property (
        bus_rd && bus_addr == 12'hF45 |=> bus_rdata == 8'h00)
        else $error("unmapped read");
    a_break_low: assert property (
        ctl_q[2] |=> !serial_tx) else $error("break not low");
    a_start_needs_en: assert property (
        $fell(serial_tx) |-> $past(ctl_q[7] | ctl_q[2]))
        else $error("tx without enable");
    a_irq_masked: assert property (
        (msk_q == 4'h0) [*2] |-> !irq) else $error("irq while masked");
    a_reset_idle: assert property (
        $rose(rst_n) |-> serial_tx && !irq && bus_rdata == 8'h00)
        else $error("reset levels");
endmodule

// ===== ucs_defs.svh
// Contract
// - Control register resets zero, eight read/write fields
// - Transmit needs enable, optionally clear-to-send low
// - Bad stop bit sets framing error
// - All-zero character sets break flag
// - Receive data read clears break flag
// - Holding-empty flag high when holding register free
// - Data write clears holding-empty until moved
// - Idle flag high only when fully sent
// - Status bit shows clear-to-send input level
// - New-frame flag marks first data byte
// - Receive data read clears new-frame flag
// - Multiprocessor status resets zero, reserved read zero
// - Bit rate is clock over sixteen times divisor
// - Disabled with timer select: divisor timer interrupts
// - Received multiprocessor bit high for address byte
`ifndef UCS_DEFS_SVH
`define UCS_DEFS_SVH
`define UCS_ADDR_W 12
`define UCS_OFF_DATA 12'hF40
`define UCS_OFF_STAT0 12'hF41
`define UCS_OFF_CTL0 12'hF42
`define UCS_OFF_CTL1 12'hF43
`define UCS_OFF_STAT1 12'hF44
`define UCS_OFF_DIV_HI 12'hF46
`define UCS_OFF_DIV_LO 12'hF47
`define UCS_OFF_IST 12'hF48
`define UCS_OFF_IMASK 12'hF49
`define UCS_CTL0_RST 8'h00
`define UCS_CTL1_RST 8'h00
`define UCS_CTL1_MASK 8'hC2
`define UCS_CTL1_MP_EN 7
`define UCS_CTL1_MP_TX 6
`define UCS_CTL1_TIMER 1
`define UCS_DIV_RST 16'h0000
`define UCS_IST_RX 0
`define UCS_IST_TXE 1
`define UCS_IST_ERR 2
`define UCS_IST_TMR 3
`define UCS_SUB_MID 4'h7
`define UCS_SUB_LAST 4'hF
`define UCS_BIT_LAST 3'h7
`endif

// ===== ucs_pkg.sv
package ucs_pkg;
    typedef enum logic [2:0] {
        UCS_IDLE = 3'h0,
        UCS_START = 3'h1,
        UCS_DATA = 3'h3,
        UCS_EXTRA = 3'h2,
        UCS_STOP = 3'h6
    } ucs_state_e;

    typedef struct packed {
        logic transmit_enable_bit;
        logic receive_enable_bit;
        logic clear_to_send_gating;
        logic parity_enable_bit;
        logic parity_odd_bit;
        logic send_break_bit;
        logic two_stop_bit;
        logic loopback_enable_bit;
    } ucs_ctl_s;

    typedef struct packed {
        ucs_state_e st;
        logic [3:0] sub;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic extra;
        logic second;
        logic line;
    } ucs_tx_s;

    typedef struct packed {
        ucs_state_e st;
        logic [3:0] sub;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic extra;
        logic second;
        logic zeros;
        logic ferr;
    } ucs_rx_s;

    typedef struct packed {
        ucs_ctl_s ctl;
        logic [7:0] ctl1;
        logic [15:0] baud_divisor;
        logic [15:0] cnt;
        logic [7:0] hold;
        logic hold_full;
        logic [7:0] rxd;
        logic avail;
        logic ferr;
        logic perr;
        logic ovr;
        logic brk;
        logic mpbit;
        logic first_frame_byte_flag;
        logic first_pend;
        logic [3:0] ist;
        logic [3:0] mask;
        logic [7:0] rdata;
        logic irq;
    } ucs_reg_s;
endpackage

// ===== ucs_remote.sv
`timescale 1ns/100ps
module ucs_remote #(
    parameter int BIT_CLKS = 32
) (
    input wire logic sys_clk,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got;
    int n_got;
    int bit_clks;
    // Clocks in the first high run after the first start bit
    initial begin
        bit_clks = 0;
        @(negedge line_in);
        @(posedge line_in);
        @(negedge sys_clk);
        while (line_in === 1'b1) begin
            bit_clks++;
            @(negedge sys_clk);
        end
    end
    initial begin
        line_out = 1'b1;
        got = 8'h00;
        n_got = 0;
    end
    // Start low, data LSB first, optional extra bit, stop; idles high
    task automatic send(input logic [7:0] d, input logic use_x,
                        input logic x, input logic stop);
        logic [10:0] f;
        f = use_x ? {stop, x, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < (use_x ? 11 : 10); i++) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge sys_clk);
        end
        line_out <= 1'b1;
    endtask
    // Samples each incoming data bit near its middle
    always begin
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge sys_clk);
            got[i] = line_in;
        end
        repeat (BIT_CLKS) @(posedge sys_clk);
        n_got++;
    end
endmodule

// ===== ucs_uart.sv
`timescale 1ns/100ps
`include "ucs_defs.svh"
module ucs_uart
    import ucs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`UCS_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic serial_rx,
    output logic serial_tx,
    input wire logic cts_n,
    output logic irq
);
    function automatic logic hit(input logic [`UCS_ADDR_W-1:0] a,
                                 input logic [`UCS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    ucs_reg_s reg_q, reg_d;
    ucs_tx_s tx_q, tx_d;
    ucs_rx_s rx_q, rx_d;
    logic tick, tick16, timer_mode, tx_ok, tx_take, rx_src;
    logic rx_fin, rx_perr;
    logic rx_prev_q, rx_prev_d;

    // Baud counter: reloads from the divisor, a pulse per expiry
    assign tick = (reg_q.cnt <= 16'h0001);
    assign timer_mode = !reg_q.ctl.transmit_enable_bit
        && !reg_q.ctl.receive_enable_bit
        && reg_q.ctl1[`UCS_CTL1_TIMER];
    assign tick16 = tick && (reg_q.ctl.transmit_enable_bit
        || reg_q.ctl.receive_enable_bit);
    assign tx_ok = reg_q.ctl.transmit_enable_bit
        && (!reg_q.ctl.clear_to_send_gating || !cts_n);
    assign tx_take = (tx_q.st == UCS_IDLE) && reg_q.hold_full && tx_ok;
    assign rx_src = reg_q.ctl.loopback_enable_bit ? tx_q.line : serial_rx;

    always_comb begin
        reg_d = reg_q;
        if (!(reg_q.ctl.transmit_enable_bit || reg_q.ctl.receive_enable_bit
              || reg_q.ctl1[`UCS_CTL1_TIMER])) begin
            reg_d.cnt = reg_q.baud_divisor;
        end else if (tick) begin
            reg_d.cnt = reg_q.baud_divisor;
        end else begin
            reg_d.cnt = reg_q.cnt - 16'h0001;
        end
        reg_d.rdata = 8'h00;
        if (bus_rd) begin
            unique case (1'b1)
                hit(bus_addr, `UCS_OFF_DATA): begin
                    reg_d.rdata = reg_q.rxd;
                    reg_d.avail = 1'b0;
                    reg_d.ferr = 1'b0;
                    reg_d.perr = 1'b0;
                    reg_d.ovr = 1'b0;
                    reg_d.brk = 1'b0;
                    reg_d.first_frame_byte_flag = 1'b0;
                end
                hit(bus_addr, `UCS_OFF_STAT0): begin
                    reg_d.rdata = {reg_q.avail, reg_q.perr, reg_q.ovr,
                        reg_q.ferr, reg_q.brk, !reg_q.hold_full,
                        !reg_q.hold_full && tx_q.st == UCS_IDLE,
                        cts_n};
                end
                hit(bus_addr, `UCS_OFF_CTL0): begin
                    reg_d.rdata = reg_q.ctl;
                end
                hit(bus_addr, `UCS_OFF_CTL1): begin
                    reg_d.rdata = reg_q.ctl1;
                end
                hit(bus_addr, `UCS_OFF_STAT1): begin
                    reg_d.rdata = {6'h00, reg_q.first_frame_byte_flag, reg_q.mpbit};
                end
                hit(bus_addr, `UCS_OFF_DIV_HI): begin
                    reg_d.rdata = reg_q.baud_divisor[15:8];
                end
                hit(bus_addr, `UCS_OFF_DIV_LO): begin
                    reg_d.rdata = reg_q.baud_divisor[7:0];
                end
                hit(bus_addr, `UCS_OFF_IST): begin
                    reg_d.rdata = {4'h0, reg_q.ist};
                    reg_d.ist = 4'h0;
                end
                hit(bus_addr, `UCS_OFF_IMASK): begin
                    reg_d.rdata = {4'h0, reg_q.mask};
                end
                default: begin
                    reg_d.rdata = 8'h00;
                end
            endcase
        end
        if (tx_take) begin
            reg_d.hold_full = 1'b0;
            reg_d.ist[`UCS_IST_TXE] = 1'b1;
        end
        if (bus_wr) begin
            unique case (1'b1)
                hit(bus_addr, `UCS_OFF_DATA): begin
                    reg_d.hold = bus_wdata;
                    reg_d.hold_full = 1'b1;
                end
                hit(bus_addr, `UCS_OFF_CTL0): begin
                    reg_d.ctl = bus_wdata;
                end
                hit(bus_addr, `UCS_OFF_CTL1): begin
                    reg_d.ctl1 = bus_wdata & `UCS_CTL1_MASK;
                end
                hit(bus_addr, `UCS_OFF_DIV_HI): begin
                    reg_d.baud_divisor[15:8] = bus_wdata;
                end
                hit(bus_addr, `UCS_OFF_DIV_LO): begin
                    reg_d.baud_divisor[7:0] = bus_wdata;
                end
                hit(bus_addr, `UCS_OFF_IMASK): begin
                    reg_d.mask = bus_wdata[3:0];
                end
                default: begin
                end
            endcase
        end
        if (timer_mode && tick) begin
            reg_d.ist[`UCS_IST_TMR] = 1'b1;
        end
        // A finishing character wins over a same-cycle read clear
        if (rx_fin) begin
            reg_d.rxd = rx_q.shift;
            reg_d.ovr = reg_q.avail && !(bus_rd
                && hit(bus_addr, `UCS_OFF_DATA));
            reg_d.avail = 1'b1;
            reg_d.ferr = rx_d.ferr;
            reg_d.brk = rx_d.zeros;
            reg_d.perr = rx_perr;
            reg_d.ist[`UCS_IST_RX] = 1'b1;
            if (rx_d.ferr || rx_perr || reg_d.ovr) begin
                reg_d.ist[`UCS_IST_ERR] = 1'b1;
            end
            if (reg_q.ctl1[`UCS_CTL1_MP_EN]) begin
                reg_d.mpbit = rx_q.extra;
                if (rx_q.extra) begin
                    reg_d.first_pend = 1'b1;
                    reg_d.first_frame_byte_flag = 1'b0;
                end else begin
                    reg_d.first_frame_byte_flag = reg_q.first_pend;
                    reg_d.first_pend = 1'b0;
                end
            end else begin
                reg_d.mpbit = 1'b0;
            end
        end
        reg_d.irq = |(reg_d.ist & reg_d.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_q <= '0;
            reg_q.ctl <= `UCS_CTL0_RST;
            reg_q.ctl1 <= `UCS_CTL1_RST;
            reg_q.baud_divisor <= `UCS_DIV_RST;
        end else begin
            reg_q <= reg_d;
        end
    end

    // Transmitter
    always_comb begin
        tx_d = tx_q;
        if (tx_take) begin
            tx_d.st = UCS_START;
            tx_d.sub = 4'h0;
            tx_d.shift = reg_q.hold;
            tx_d.second = 1'b0;
            tx_d.extra = reg_q.ctl1[`UCS_CTL1_MP_EN]
                ? reg_q.ctl1[`UCS_CTL1_MP_TX]
                : (^reg_q.hold) ^ reg_q.ctl.parity_odd_bit;
        end else if (tx_q.st != UCS_IDLE && tick16) begin
            tx_d.sub = tx_q.sub + 4'h1;
            if (tx_q.sub == `UCS_SUB_LAST) begin
                unique case (tx_q.st)
                    UCS_START: begin
                        tx_d.st = UCS_DATA;
                        tx_d.cnt = 3'h0;
                    end
                    UCS_DATA: begin
                        tx_d.shift = {1'b0, tx_q.shift[7:1]};
                        tx_d.cnt = tx_q.cnt + 3'h1;
                        if (tx_q.cnt == `UCS_BIT_LAST) begin
                            tx_d.st = (reg_q.ctl.parity_enable_bit
                                || reg_q.ctl1[`UCS_CTL1_MP_EN])
                                ? UCS_EXTRA : UCS_STOP;
                        end
                    end
                    UCS_EXTRA: begin
                        tx_d.st = UCS_STOP;
                    end
                    UCS_STOP: begin
                        if (reg_q.ctl.two_stop_bit && !tx_q.second) begin
                            tx_d.second = 1'b1;
                        end else begin
                            tx_d.st = UCS_IDLE;
                        end
                    end
                    default: begin
                        tx_d.st = UCS_IDLE;
                    end
                endcase
            end
        end
        unique case (tx_d.st)
            UCS_START: tx_d.line = 1'b0;
            UCS_DATA: tx_d.line = tx_d.shift[0];
            UCS_EXTRA: tx_d.line = tx_d.extra;
            default: tx_d.line = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_q <= '0;
            tx_q.st <= UCS_IDLE;
            tx_q.line <= 1'b1;
            serial_tx <= 1'b1;
        end else begin
            tx_q <= tx_d;
            serial_tx <= tx_d.line && !reg_q.ctl.send_break_bit;
        end
    end

    // Receiver
    always_comb begin
        rx_d = rx_q;
        rx_prev_d = rx_src;
        rx_fin = 1'b0;
        rx_perr = 1'b0;
        if (!reg_q.ctl.receive_enable_bit) begin
            rx_d.st = UCS_IDLE;
        end else if (rx_q.st == UCS_IDLE) begin
            // Needs a falling edge, so a line held low is not a start
            if (rx_prev_q && !rx_src) begin
                rx_d.st = UCS_START;
                rx_d.sub = 4'h0;
                rx_d.zeros = 1'b1;
                rx_d.ferr = 1'b0;
                rx_d.second = 1'b0;
            end
        end else if (tick16) begin
            rx_d.sub = rx_q.sub + 4'h1;
            if (rx_q.st == UCS_START) begin
                if (rx_q.sub == `UCS_SUB_MID) begin
                    rx_d.st = rx_src ? UCS_IDLE : UCS_DATA;
                    rx_d.sub = 4'h0;
                    rx_d.cnt = 3'h0;
                end
            end else if (rx_q.sub == `UCS_SUB_LAST) begin
                if (rx_src) begin
                    rx_d.zeros = 1'b0;
                end
                unique case (rx_q.st)
                    UCS_DATA: begin
                        rx_d.shift = {rx_src, rx_q.shift[7:1]};
                        rx_d.cnt = rx_q.cnt + 3'h1;
                        if (rx_q.cnt == `UCS_BIT_LAST) begin
                            rx_d.st = (reg_q.ctl.parity_enable_bit
                                || reg_q.ctl1[`UCS_CTL1_MP_EN])
                                ? UCS_EXTRA : UCS_STOP;
                        end
                    end
                    UCS_EXTRA: begin
                        rx_d.extra = rx_src;
                        rx_d.st = UCS_STOP;
                    end
                    UCS_STOP: begin
                        if (!rx_src) begin
                            rx_d.ferr = 1'b1;
                        end
                        if (reg_q.ctl.two_stop_bit && !rx_q.second) begin
                            rx_d.second = 1'b1;
                        end else begin
                            rx_d.st = UCS_IDLE;
                            rx_fin = 1'b1;
                            rx_perr = reg_q.ctl.parity_enable_bit
                                && !reg_q.ctl1[`UCS_CTL1_MP_EN]
                                && (((^rx_q.shift) ^ rx_q.extra)
                                    != reg_q.ctl.parity_odd_bit);
                        end
                    end
                    default: begin
                        rx_d.st = UCS_IDLE;
                    end
                endcase
            end
        end
        if (rx_q.st == UCS_DATA && rx_q.cnt == 3'h0
            && rx_q.sub == 4'h0) begin
            rx_d.extra = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_q <= '0;
            rx_q.st <= UCS_IDLE;
            rx_prev_q <= 1'b1;
            bus_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            rx_q <= rx_d;
            rx_prev_q <= rx_prev_d;
            bus_rdata <= reg_d.rdata;
            irq <= reg_d.irq;
        end
    end
endmodule
